// *** rtl/reset_timeout_sequencer.sv ***
// Purpose: reset pin filter, power-up delay, oscillator start-up wait
//          and reset-cause flags
// Assumes: slow RC and oscillator clocks arrive as sampled levels
// Notes: the reset pin is never driven by this block
`timescale 1ns/1ps
`default_nettype none

module reset_timeout_sequencer
    import rst_seq_pkg::*;
(
    // clock and reset
    input wire logic clock,
    input wire logic nrst,
    // register port
    input wire bus_req_t bus,
    output logic [`DATA_W-1:0] rdata,
    // pins and analog sources
    input wire async_in_t ain,
    // core events
    input wire core_ev_t ev,
    // reset and clock control
    output logic chip_reset_n,
    output logic osc_run,
    output logic wdt_clear,
    // pin side
    output logic pullup_en,
    output logic port_a_line3
);

    localparam logic [`CNT_W-1:0] POWERUP_DELAY_TIMER_LAST = `CNT_W'(`POWERUP_DELAY_TIMER_TICKS - 1);
    localparam logic [`CNT_W-1:0] OST_LAST = `CNT_W'(`OST_PERIODS - 1);
    localparam logic [`CNT_W-1:0] FILT_LAST =
        `CNT_W'(`PIN_FILTER_CYCLES - 1);

    seq_regs_t r_reg;
    seq_regs_t r_next;

    // decoded configuration and synchronised conditions
    logic pin_sel;
    logic powerup_delay_timer_dis;
    logic [1:0] bo_en;
    osc_mode_t osc_mode;
    logic crystal;
    logic rc_edge;
    logic osc_edge;
    logic bor_hold;
    logic pin_low;
    logic [`DATA_W-1:0] cause_rd;
    logic [`DATA_W-1:0] stat_rd;

    assign pin_sel = r_reg.cfg[`CFG_PINSEL_BIT];
    assign powerup_delay_timer_dis = r_reg.cfg[`CFG_PWRTDIS_BIT];
    assign bo_en = r_reg.cfg[`CFG_BOEN_LSB +: 2];
    assign osc_mode = osc_mode_t'(r_reg.cfg[`CFG_OSC_LSB +: 3]);
    // crystal-type oscillators need a start-up wait
    assign crystal = (osc_mode == OSC_LP) || (osc_mode == OSC_XT) ||
                     (osc_mode == OSC_HS);
    // edges seen on the second and third stages only
    assign rc_edge = r_reg.rc_s2 && !r_reg.rc_s3;
    assign osc_edge = r_reg.osc_s2 && !r_reg.osc_s3;
    // brown-out hold only when detection is enabled
    assign bor_hold = (bo_en != `BOEN_OFF) && r_reg.bor_s2;
    // internal reset mode ignores the pin as a reset source
    assign pin_low = pin_sel && !r_reg.pin_filt;

    // read views of the two flag registers
    always_comb begin
        cause_rd = '0;
        cause_rd[`CAUSE_BO_BIT] = r_reg.bo_flag;
        cause_rd[`CAUSE_PO_BIT] = r_reg.po_flag;
        stat_rd = {r_reg.stat_hi, r_reg.to_flag, r_reg.pd_flag,
                   r_reg.stat_lo};
    end

    // next state of the whole block
    always_comb begin
        r_next = r_reg;

        // two-stage synchronisers, with a third stage on the RC and oscillator clocks
        r_next.pin_s1 = ain.ext_reset_pin;
        r_next.pin_s2 = r_reg.pin_s1;
        r_next.rc_s1 = ain.rc_clk;
        r_next.rc_s2 = r_reg.rc_s1;
        r_next.rc_s3 = r_reg.rc_s2;
        r_next.osc_s1 = ain.osc_clk;
        r_next.osc_s2 = r_reg.osc_s1;
        r_next.osc_s3 = r_reg.osc_s2;
        r_next.por_s1 = ain.por_active;
        r_next.por_s2 = r_reg.por_s1;
        r_next.bor_s1 = ain.bor_low;
        r_next.bor_s2 = r_reg.bor_s1;

        // glitch filter: level accepted only after it stays stable
        if (r_reg.pin_s2 == r_reg.pin_filt) begin
            r_next.filt_cnt = '0;
        end else if (r_reg.filt_cnt == FILT_LAST) begin
            r_next.filt_cnt = '0;
            r_next.pin_filt = r_reg.pin_s2;
        end else begin
            r_next.filt_cnt = r_reg.filt_cnt + `CNT_W'(1);
        end

        // pulses default low
        r_next.wdt_clear = 1'b0;
        r_next.wdt_rst = 1'b0;

        // software writes; hardware events below override them
        if (bus.wr) begin
            case (bus.addr)
                `ADDR_CAUSE: begin
                    r_next.bo_flag = bus.wdata[`CAUSE_BO_BIT];
                    r_next.po_flag = bus.wdata[`CAUSE_PO_BIT];
                end
                `ADDR_STATUS: begin
                    r_next.stat_hi = bus.wdata[`DATA_W-1:`STAT_HI_LSB];
                    r_next.stat_lo = bus.wdata[`STAT_LO_MSB:0];
                end
                `ADDR_CFG: begin
                    r_next.cfg = bus.wdata;
                end
                default: begin
                end
            endcase
        end

        // sequencer
        case (r_reg.st)
            ST_HOLD: begin
                r_next.cnt = '0;
                r_next.osc_run = 1'b1;
                if (!r_reg.por_s2 && !bor_hold) begin
                    if (!powerup_delay_timer_dis) begin
                        r_next.st = ST_POWERUP_DELAY_TIMER;
                    end else if (crystal) begin
                        r_next.st = ST_OST;
                    end else begin
                        r_next.st = ST_RUN;
                    end
                end
            end
            ST_POWERUP_DELAY_TIMER: begin
                if (rc_edge) begin
                    if (r_reg.cnt == POWERUP_DELAY_TIMER_LAST) begin
                        r_next.cnt = '0;
                        r_next.st = crystal ? ST_OST : ST_RUN;
                    end else begin
                        r_next.cnt = r_reg.cnt + `CNT_W'(1);
                    end
                end
            end
            ST_OST: begin
                r_next.osc_run = 1'b1;
                if (osc_edge) begin
                    if (r_reg.cnt == OST_LAST) begin
                        r_next.cnt = '0;
                        r_next.st = ST_RUN;
                    end else begin
                        r_next.cnt = r_reg.cnt + `CNT_W'(1);
                    end
                end
            end
            ST_RUN: begin
                if (ev.wdt_expire) begin
                    // watchdog reset: one-cycle internal pulse, pin untouched
                    r_next.wdt_rst = 1'b1;
                    r_next.to_flag = 1'b0;
                    r_next.stat_hi = '0;
                end else if (pin_low) begin
                    r_next.stat_hi = '0;
                end else if (ev.sleep_exec) begin
                    r_next.to_flag = 1'b1;
                    r_next.pd_flag = 1'b0;
                    r_next.wdt_clear = 1'b1;
                    r_next.osc_run = 1'b0;
                    r_next.st = ST_SLEEP;
                end
            end
            ST_SLEEP: begin
                if (ev.wdt_expire) begin
                    // watchdog wake-up
                    r_next.to_flag = 1'b0;
                    r_next.pd_flag = 1'b0;
                    r_next.osc_run = 1'b1;
                    r_next.st = crystal ? ST_OST : ST_RUN;
                end else if (pin_low) begin
                    // pin reset during sleep
                    r_next.to_flag = 1'b1;
                    r_next.pd_flag = 1'b0;
                    r_next.stat_hi = '0;
                    r_next.osc_run = 1'b1;
                    r_next.st = crystal ? ST_OST : ST_RUN;
                end
            end
            default: begin
                r_next.st = ST_HOLD;
            end
        endcase

        // power-on and brown-out win over everything else
        if (r_reg.por_s2) begin
            r_next.st = ST_HOLD;
            r_next.po_flag = 1'b0;
            r_next.to_flag = 1'b1;
            r_next.pd_flag = 1'b1;
            r_next.stat_hi = '0;
            r_next.stat_lo = '0;
            r_next.cnt = '0;
        end else if (bor_hold) begin
            r_next.st = ST_HOLD;
            r_next.bo_flag = 1'b0;
            r_next.to_flag = 1'b1;
            r_next.pd_flag = 1'b1;
            r_next.stat_hi = '0;
            r_next.stat_lo = '0;
            r_next.cnt = '0;
        end

        // chip released only when time-outs are done and, in pin reset mode, pin is high
        r_next.chip_rst_n = (r_reg.st == ST_RUN || r_reg.st == ST_SLEEP) &&
                            !r_reg.por_s2 && !bor_hold && !pin_low &&
                            !r_reg.wdt_rst;

        // pin side: pull-up in pin reset mode, data line otherwise
        r_next.pullup_en = pin_sel;
        r_next.port_a_line3 = pin_sel ? 1'b0 : r_reg.pin_s2;

        // read data, one cycle after the strobe
        if (bus.rd) begin
            case (bus.addr)
                `ADDR_CAUSE: r_next.rdata = cause_rd;
                `ADDR_STATUS: r_next.rdata = stat_rd;
                `ADDR_CFG: r_next.rdata = r_reg.cfg;
                default: r_next.rdata = '0;
            endcase
        end else begin
            r_next.rdata = '0;
        end
    end

    // state register with synchronous reset
    always_ff @(posedge clock) begin
        if (!nrst) begin
            r_reg <= '0;
            r_reg.st <= ST_HOLD;
            r_reg.cfg <= `CFG_RESET;
            r_reg.pin_filt <= 1'b1;
            r_reg.to_flag <= 1'b1;
            r_reg.pd_flag <= 1'b1;
            r_reg.osc_run <= 1'b1;
        end else begin
            r_reg <= r_next;
        end
    end

    // outputs straight from flip-flops
    assign rdata = r_reg.rdata;
    assign chip_reset_n = r_reg.chip_rst_n;
    assign osc_run = r_reg.osc_run;
    assign wdt_clear = r_reg.wdt_clear;
    assign pullup_en = r_reg.pullup_en;
    assign port_a_line3 = r_reg.port_a_line3;

endmodule : reset_timeout_sequencer

`default_nettype wire

// *** rtl/rst_seq_cfg.svh ***
// Purpose: constants of the reset and time-out sequencer
// Assumes: 50 MHz system clock, slow internal RC clock sampled as a pin
// Notes: times are kept in their own unit, counts are derived from them
`ifndef RST_SEQ_CFG_SVH
`define RST_SEQ_CFG_SVH

// clock and bus widths
`define CLK_PERIOD_NS 20
`define ADDR_W 8
`define DATA_W 8
`define CNT_W 16

// register addresses
`define ADDR_CAUSE 8'h8E
`define ADDR_STATUS 8'h83
`define ADDR_CFG 8'h81

// reset-cause register fields
`define CAUSE_BO_BIT 0
`define CAUSE_PO_BIT 1

// core status register fields
`define STAT_TO_BIT 4
`define STAT_PD_BIT 3
`define STAT_HI_LSB 5
`define STAT_LO_MSB 2

// configuration register fields and reset value
`define CFG_PINSEL_BIT 0
`define CFG_PWRTDIS_BIT 1
`define CFG_BOEN_LSB 2
`define CFG_OSC_LSB 4
`define CFG_RESET 8'h01

// brown-out enable value that turns detection off
`define BOEN_OFF 2'h0

// power-up delay: 64 ms counted on the internal RC clock
`define POWERUP_DELAY_TIMER_TIME_MS 64
`define RC_FREQ_KHZ 32
`define POWERUP_DELAY_TIMER_TICKS (`POWERUP_DELAY_TIMER_TIME_MS * `RC_FREQ_KHZ)

// oscillator start-up wait in oscillator periods
`define OST_PERIODS 1024

// reset pin glitch filter, a least time so it rounds up
`define PIN_FILTER_NS 200
`define PIN_FILTER_CYCLES \
    ((`PIN_FILTER_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// *** rtl/rst_seq_pkg.sv ***
// Purpose: types shared by the reset and time-out sequencer
// Assumes: constants come from the cfg header
// Notes: one-hot sequencer states
`include "rst_seq_cfg.svh"

package rst_seq_pkg;

    // sequencer states, one-hot
    typedef enum logic [4:0] {
        ST_HOLD  = 5'h01,
        ST_POWERUP_DELAY_TIMER  = 5'h02,
        ST_OST   = 5'h04,
        ST_RUN   = 5'h08,
        ST_SLEEP = 5'h10
    } seq_state_t;

    // main oscillator modes
    typedef enum logic [2:0] {
        OSC_LP  = 3'h0,
        OSC_XT  = 3'h1,
        OSC_HS  = 3'h2,
        OSC_EC  = 3'h3,
        OSC_INT = 3'h4,
        OSC_RC  = 3'h5
    } osc_mode_t;

    // register port request
    typedef struct packed {
        logic [`ADDR_W-1:0] addr;
        logic [`DATA_W-1:0] wdata;
        logic wr;
        logic rd;
    } bus_req_t;

    // asynchronous inputs from the pad ring and analog blocks
    typedef struct packed {
        logic ext_reset_pin;
        logic rc_clk;
        logic osc_clk;
        logic por_active;
        logic bor_low;
    } async_in_t;

    // events from logic on the system clock
    typedef struct packed {
        logic wdt_expire;
        logic sleep_exec;
    } core_ev_t;

    // all state of the sequencer
    typedef struct packed {
        seq_state_t st;
        logic pin_s1;
        logic pin_s2;
        logic rc_s1;
        logic rc_s2;
        logic rc_s3;
        logic osc_s1;
        logic osc_s2;
        logic osc_s3;
        logic por_s1;
        logic por_s2;
        logic bor_s1;
        logic bor_s2;
        logic [`CNT_W-1:0] filt_cnt;
        logic pin_filt;
        logic [`CNT_W-1:0] cnt;
        logic [`DATA_W-1:0] cfg;
        logic po_flag;
        logic bo_flag;
        logic to_flag;
        logic pd_flag;
        logic [2:0] stat_hi;
        logic [2:0] stat_lo;
        logic wdt_rst;
        logic chip_rst_n;
        logic osc_run;
        logic wdt_clear;
        logic pullup_en;
        logic port_a_line3;
        logic [`DATA_W-1:0] rdata;
    } seq_regs_t;

endpackage : rst_seq_pkg

// *** verif/rst_seq_properties.sv ***
// Purpose: port checks of the reset sequencer
// Assumes: one clock, nrst synchronous active low
// Notes: bound to the design top below
`timescale 1ns/1ps
`default_nettype none
`include "rst_seq_cfg.svh"
module rst_seq_properties
    import rst_seq_pkg::*;
(
    // clock and reset
    input wire logic clock,
    input wire logic nrst,
    // inputs
    input wire bus_req_t bus,
    input wire async_in_t ain,
    input wire core_ev_t ev,
    // outputs
    input wire logic [`DATA_W-1:0] rdata,
    input wire logic chip_reset_n,
    input wire logic osc_run,
    input wire logic wdt_clear,
    input wire logic pullup_en,
    input wire logic port_a_line3
);
    logic [4:0] low_cnt;
    logic run;
    assign run = chip_reset_n && osc_run;
    default clocking @(posedge clock); endclocking
    default disable iff (!nrst);
    // consecutive low samples of the pin
    always_ff @(posedge clock) begin
        if (ain.ext_reset_pin) begin
            low_cnt <= 5'h00;
        end else if (low_cnt != 5'h1F) begin
            low_cnt <= low_cnt + 5'h01;
        end
    end
    rd_idle_a: assert property (!$past(bus.rd) |-> rdata == 8'h00)
        else $error("read data without read");
    cause_top_a: assert property (bus.rd && bus.addr == `ADDR_CAUSE
        |=> rdata[7:2] == 6'h00) else $error("cause upper bits set");
    pin_owner_a: assert property (pullup_en && $past(pullup_en)
        |-> !port_a_line3) else $error("pin data while reset pin");
    sleep_wdt_a: assert property (ev.sleep_exec && run
        |-> ##[1:3] wdt_clear) else $error("no watchdog clear");
    sleep_osc_a: assert property (ev.sleep_exec && run
        |-> ##[1:3] !osc_run) else $error("oscillator kept on");
    wdt_reset_a: assert property (ev.wdt_expire && run && pullup_en
        && ain.ext_reset_pin |-> ##2 !chip_reset_n ##1 chip_reset_n)
        else $error("watchdog reset pulse wrong");
    wdt_pin_a: assert property (ev.wdt_expire
        |=> $stable(pullup_en) [*3]) else $error("pin control moved");
    glitch_a: assert property (run && pullup_en && ain.ext_reset_pin
        ##1 !ain.ext_reset_pin [*5] ##1 ain.ext_reset_pin
        |-> chip_reset_n [*6]) else $error("glitch caused reset");
    pin_hold_a: assert property (pullup_en && low_cnt == 5'h0E
        |-> ##[0:4] !chip_reset_n) else $error("long low pin ignored");
    por_hold_a: assert property (ain.por_active [*5]
        |-> !chip_reset_n) else $error("running during power-on");
    // main scenarios reached
    cover property (ev.wdt_expire && run);
    cover property (ev.sleep_exec && run);
    cover property (ev.wdt_expire && !osc_run);
endmodule : rst_seq_properties

bind reset_timeout_sequencer rst_seq_properties i_rst_seq_properties (
    .clock(clock), .nrst(nrst), .bus(bus), .ain(ain), .ev(ev),
    .rdata(rdata), .chip_reset_n(chip_reset_n), .osc_run(osc_run),
    .wdt_clear(wdt_clear), .pullup_en(pullup_en),
    .port_a_line3(port_a_line3)
);
`default_nettype wire

// *** verif/reset_source_model.sv ***
// Purpose: external source of the reset pin
// Assumes: no pull on the pin while the pull-up is off
// Notes: a free pin with no pull toggles every clock
`timescale 1ns/1ps
`default_nettype none
module reset_source_model (
    // clock
    input wire logic clock,
    // pin side
    input wire logic pullup_en,
    output logic pin
);
    logic drive_low = 1'b0;
    logic float_val = 1'b0;
    // level of a free pin with no pull
    always @(posedge clock) begin
        float_val <= ~float_val;
    end
    assign pin = drive_low ? 1'b0 : (pullup_en ? 1'b1 : float_val);
    // hold or free the pin from the next edge
    task automatic hold(input logic low);
        @(posedge clock);
        drive_low <= low;
    endtask : hold
    // low pulse of n clocks
    task automatic pull_low(input int n);
        hold(1'b1);
        repeat (n) @(posedge clock);
        drive_low <= 1'b0;
    endtask : pull_low
endmodule : reset_source_model
`default_nettype wire

// *** verif/reset_timeout_sequencer_tb.sv ***
// Purpose: self-checking bench of the reset sequencer
// Assumes: slow clocks made by dividing the system clock
// Notes: reads are checked by a monitor from a queue
`timescale 1ns/1ps
`default_nettype none
`include "rst_seq_cfg.svh"
module reset_timeout_sequencer_tb
    import rst_seq_pkg::*;
;
    localparam int div_n = 3;
    localparam int tpwrt = `POWERUP_DELAY_TIMER_TICKS * 2 * div_n;
    localparam int tost = `OST_PERIODS * 2 * div_n;
    localparam core_ev_t ev_sleep = '{1'b0, 1'b1};
    localparam core_ev_t ev_wdt = '{1'b1, 1'b0};
    logic clock, nrst, rc, osc, por, bor, pin, rd_seen;
    logic chip_reset_n, osc_run, wdt_clear, pullup_en, port_a_line3;
    logic [`DATA_W-1:0] rdata;
    logic [7:0] v;
    logic [7:0] exp_q[$];
    int div, n_mismatch, comparisons;
    bus_req_t bus;
    core_ev_t ev;
    async_in_t ain;
    assign ain = '{pin, rc, osc, por, bor};

    reset_timeout_sequencer i_reset_timeout_sequencer (
        .clock(clock), .nrst(nrst), .bus(bus), .rdata(rdata), .ain(ain),
        .ev(ev), .chip_reset_n(chip_reset_n), .osc_run(osc_run),
        .wdt_clear(wdt_clear), .pullup_en(pullup_en),
        .port_a_line3(port_a_line3)
    );
    reset_source_model i_reset_source_model (
        .clock(clock), .pullup_en(pullup_en), .pin(pin)
    );

    // system clock
    initial begin
        clock = 1'b0;
        forever #10 clock = ~clock;
    end
    // RC clock runs free, oscillator only while enabled
    always @(posedge clock) begin
        div <= (div == div_n - 1) ? 0 : div + 1;
        if (div == div_n - 1) begin
            rc <= ~rc;
            osc <= osc_run ? ~osc : osc;
        end
    end
    // read data checked in the cycle after the strobe
    always @(posedge clock) begin
        rd_seen <= bus.rd;
    end
    always @(negedge clock) begin
        if (rd_seen === 1'b1) begin
            chk(rdata, exp_q.pop_front());
        end
    end

    function automatic logic [7:0] lfsr(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction : lfsr
    task automatic chk(input logic [7:0] seen, input logic [7:0] e);
        comparisons++;
        if (seen !== e) begin
            n_mismatch++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, e);
        end
    endtask : chk
    // one register cycle, a read notes its expected data
    task automatic acc(input logic w, input logic [7:0] a, d);
        if (!w) exp_q.push_back(d);
        @(posedge clock);
        bus <= '{addr: a, wdata: d, wr: w, rd: !w};
        @(posedge clock);
        bus <= '0;
    endtask : acc
    task automatic pulse(input core_ev_t e);
        @(posedge clock);
        ev <= e;
        @(posedge clock);
        ev <= '0;
    endtask : pulse
    // power-on pulse, or brown-out pulse when b is set
    task automatic supply(input logic b);
        @(posedge clock);
        por <= !b;
        bor <= b;
        repeat (8) @(posedge clock);
        por <= 1'b0;
        bor <= 1'b0;
    endtask : supply
    task automatic waitn(input int n);
        repeat (n) @(negedge clock);
    endtask : waitn
    // cycles until the chip leaves reset, within lo..hi
    task automatic wait_rel(input int lo, input int hi);
        int n;
        n = 0;
        while (chip_reset_n !== 1'b1 && n <= hi) begin
            @(negedge clock);
            n++;
        end
        chk(8'(n >= lo && n <= hi), 8'h01);
    endtask : wait_rel
    task automatic end_sim();
        if (n_mismatch == 0 && comparisons > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : end_sim

    // cut a hang short
    initial begin
        repeat (90000) @(posedge clock);
        n_mismatch++;
        end_sim();
    end
    // main sequence
    initial begin
        nrst = 1'b0;
        bus = '0;
        ev = '0;
        rc = 1'b0;
        osc = 1'b0;
        por = 1'b1;
        bor = 1'b0;
        div = 0;
        rd_seen = 1'b0;
        v = 8'h5D;
        n_mismatch = 0;
        comparisons = 0;
        repeat (4) @(posedge clock);
        nrst <= 1'b1;
        i_reset_source_model.hold(1'b1);
        acc(1'b0, `ADDR_CFG, `CFG_RESET);
        acc(1'b0, `ADDR_CAUSE, 8'h00);
        acc(1'b0, `ADDR_STATUS, 8'h18);
        acc(1'b0, 8'h20, 8'h00);
        chk(8'(pullup_en), 8'h01);
        @(posedge clock);
        por <= 1'b0;
        waitn(tpwrt + tost + 200);
        chk(8'(chip_reset_n), 8'h00);
        i_reset_source_model.hold(1'b0);
        wait_rel(0, 30);
        v = lfsr(v);
        acc(1'b1, `ADDR_STATUS, v);
        acc(1'b0, `ADDR_STATUS, (v & 8'hE7) | 8'h18);
        i_reset_source_model.pull_low(5);
        waitn(20);
        chk(8'(chip_reset_n), 8'h01);
        i_reset_source_model.pull_low(30);
        waitn(1);
        chk(8'(chip_reset_n), 8'h00);
        wait_rel(1, 40);
        acc(1'b0, `ADDR_STATUS, (v & 8'h07) | 8'h18);
        v = lfsr(v);
        acc(1'b1, `ADDR_STATUS, v);
        pulse(ev_wdt);
        waitn(8);
        acc(1'b0, `ADDR_STATUS, (v & 8'h07) | 8'h08);
        acc(1'b1, `ADDR_CAUSE, 8'hFF);
        acc(1'b0, `ADDR_CAUSE, 8'h03);
        acc(1'b1, `ADDR_CFG, 8'h33);
        supply(1'b0);
        wait_rel(0, 12);
        acc(1'b0, `ADDR_CAUSE, 8'h01);
        acc(1'b0, `ADDR_STATUS, 8'h18);
        pulse(ev_sleep);
        waitn(4);
        chk(8'(osc_run), 8'h00);
        acc(1'b0, `ADDR_STATUS, 8'h10);
        pulse(ev_wdt);
        waitn(8);
        chk(8'(osc_run), 8'h01);
        acc(1'b0, `ADDR_STATUS, 8'h00);
        pulse(ev_sleep);
        i_reset_source_model.pull_low(30);
        wait_rel(1, 40);
        acc(1'b0, `ADDR_STATUS, 8'h10);
        acc(1'b1, `ADDR_CFG, 8'h11);
        supply(1'b0);
        wait_rel(tpwrt + tost - 8, tpwrt + tost + 40);
        acc(1'b1, `ADDR_CFG, 8'h41);
        supply(1'b0);
        wait_rel(tpwrt - 8, tpwrt + 40);
        acc(1'b1, `ADDR_CAUSE, 8'h03);
        acc(1'b1, `ADDR_CFG, 8'h35);
        supply(1'b1);
        wait_rel(tpwrt - 8, tpwrt + 40);
        acc(1'b0, `ADDR_CAUSE, 8'h02);
        acc(1'b0, `ADDR_STATUS, 8'h18);
        acc(1'b1, `ADDR_CFG, 8'h30);
        waitn(4);
        chk(8'(pullup_en), 8'h00);
        i_reset_source_model.hold(1'b1);
        waitn(20);
        chk(8'(chip_reset_n), 8'h01);
        chk(8'(port_a_line3), 8'h00);
        i_reset_source_model.hold(1'b0);
        end_sim();
    end
endmodule : reset_timeout_sequencer_tb
`default_nettype wire
